// File: core/ldfs_consts.vh
// ldfs_consts.vh: offsets, field positions, reset values and timing counts of the fault supervisor
// assumes a 25 MHz pclk; times are kept in their own units and turned into cycle counts here
`ifndef LDFS_CONSTS_VH
`define LDFS_CONSTS_VH

`define LDFS_CLK_HZ            25000000
`define LDFS_OTP_BLANK_US      250
`define LDFS_OTP_BLANK_CYC     ((`LDFS_OTP_BLANK_US * (`LDFS_CLK_HZ / 1000000)))
`define LDFS_BO_BLANK_MS       25
`define LDFS_BO_BLANK_CYC      (`LDFS_BO_BLANK_MS * (`LDFS_CLK_HZ / 1000))
`define LDFS_GND_PERSIST_US    200
`define LDFS_GND_PERSIST_CYC   (`LDFS_GND_PERSIST_US * (`LDFS_CLK_HZ / 1000000))
`define LDFS_AUX_TIMEOUT_MS    90
`define LDFS_AUX_TIMEOUT_CYC   (`LDFS_AUX_TIMEOUT_MS * (`LDFS_CLK_HZ / 1000))
`define LDFS_AUTO_DELAY_S      4
`define LDFS_AUTO_DELAY_CYC    (`LDFS_AUTO_DELAY_S * `LDFS_CLK_HZ)
`define LDFS_SHORT_PERIODS     4

// register map (APB, byte addresses)
`define LDFS_ADDR_STATUS       12'h000
`define LDFS_ADDR_FAULTS       12'h004
`define LDFS_ADDR_CTRL         12'h008
`define LDFS_ADDR_FOLDBACK     12'h00c

// fault bit positions in FAULTS
`define LDFS_F_OTP             0
`define LDFS_F_PROGRAMMABLE_OVERVOLTAGE_FAULT            1
`define LDFS_F_WOD             2
`define LDFS_F_AUX             3
`define LDFS_F_VCC_OVP         4
`define LDFS_F_TSD             5
`define LDFS_F_CS_SHORT        6
`define LDFS_F_GND             7
`define LDFS_F_BROWNOUT        8
`define LDFS_NFAULT            9

// status bit positions
`define LDFS_S_RUN             0
`define LDFS_S_LATCHED         1
`define LDFS_S_AUTO_WAIT       2
`define LDFS_S_LATCH_VAR       3
`define LDFS_S_BLANKING        4
`define LDFS_S_STARTUP_LOW     5

// control reset value: bit0 enables foldback
`define LDFS_CTRL_RESET        32'h0000_0001
`define LDFS_FOLD_FULL         8'hff
`define LDFS_FOLD_HALF         8'h80

`endif

// File: core/ldfs_persist.v
// ldfs_persist.v: counts cycles a condition holds continuously, flags once the count is reached
// assumes synchronous inputs and a shared clock enable
`timescale 1ns/1ps
module ldfs_persist #(
  parameter W     = 32,
  parameter LIMIT = 100
) (
  input  wire         pclk,
  input  wire         presetn,
  input  wire         clk_en,
  input  wire         cond,
  output reg          hit
);
  reg [W-1:0] cnt_q;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= {W{1'b0}};
      hit   <= 1'b0;
    end else if (clk_en) begin
      // any gap in the condition restarts the count
      if (!cond) begin
        cnt_q <= {W{1'b0}};
        hit   <= 1'b0;
      end else if (cnt_q >= LIMIT[W-1:0] - 1'b1) begin
        hit   <= 1'b1;
      end else begin
        cnt_q <= cnt_q + 1'b1;
      end
    end
  end
endmodule // ldfs_persist

// File: core/ldfs_supervisor.v
// ldfs_supervisor.v: fault supervisor of an LED driver controller, with APB register view
// assumes comparator levels synchronous to pclk; presetn is the supply-derived reset (supply below reset level)
// only comparator levels come in; thresholds, current loop and gate driver stay outside
// Notes on behaviour
// - thermal level below start lowers current target, half at stop level.
// - severe overtemp inhibits until thermal level rises above recovery level.
// - latching variant needs supply reset to restart after severe overtemp.
// - ignore overtemp comparator 250 us after supply reaches turn-on level.
// - brown-out only after line level low continuously over 25 ms.
// - brown-out recovery needs line above exit level and supply on.
// - on brown-out recovery enter low start-up consumption, then restart.
// - die overheat stops operation until indication clears.
// - test current-sense impedance at start-up and after max on-time pulses.
// - ground fault persisting 200 us stops drive pulses.
// - any major fault inhibits gate-drive pulses.
// - latching fault holds inhibit until supply reset clears it.
// - auto-recovery fault inhibits 4 s, then resumes once supply on.
// - latching variant latches thermal-pin faults and short faults; else auto-recover.
// - aux short fault after 90 ms without valley-detect short-threshold pulse.
// - diode or winding short after four consecutive periods above 150 percent limit.
// - supply overvoltage stops pulsing and always auto-recovers.
//
// The APB slave port and the address map are this design's own decisions.
`timescale 1ns/1ps
`include "ldfs_consts.vh"
module ldfs_supervisor #(
  parameter BO_BLANK_CYC   = `LDFS_BO_BLANK_CYC,
  parameter AUX_TIMEOUT_CYC = `LDFS_AUX_TIMEOUT_CYC,
  parameter AUTO_DELAY_CYC = `LDFS_AUTO_DELAY_CYC,
  parameter OTP_BLANK_CYC  = `LDFS_OTP_BLANK_CYC,
  parameter GND_CYC        = `LDFS_GND_PERSIST_CYC
) (
  input  wire         pclk,
  input  wire         presetn,
  input  wire         clk_en,
  input  wire         latch_variant_sel,
  input  wire         vcc_on,
  input  wire         thermal_below_start,
  input  wire         thermal_below_stop,
  input  wire         thermal_below_otp,
  input  wire         thermal_above_recover,
  input  wire         thermal_overvoltage,
  input  wire         line_below_enter,
  input  wire         line_above_exit,
  input  wire         die_overheat,
  input  wire         vcc_overvoltage,
  input  wire         cs_impedance_low,
  input  wire         maxon_pulse_end,
  input  wire         gnd_diode_fault,
  input  wire         valley_short_pulse,
  input  wire         period_end,
  input  wire         cs_over_150,
  input  wire [7:0]   foldback_position,
  input  wire         psel,
  input  wire         penable,
  input  wire         pwrite,
  input  wire [11:0]  paddr,
  input  wire [31:0]  pwdata,
  output reg  [31:0]  prdata,
  output wire         pready,
  output wire         pslverr,
  output wire         drive_enable,
  output reg          startup_low_power,
  output reg  [7:0]   current_target
);
  localparam ST_START = 2'd0;
  localparam ST_RUN   = 2'd1;
  localparam ST_AUTO  = 2'd2;
  localparam ST_LATCH = 2'd3;

  reg [1:0]            state_q;
  reg                  latch_var_q;
  reg                  seen_on_q;
  reg [31:0]           blank_q;
  reg [31:0]           aux_q;
  reg [31:0]           auto_q;
  reg [2:0]            short_q;
  reg                  otp_q;
  reg                  wod_q;
  reg                  aux_q_flag;
  reg                  cs_short_q;
  reg                  brownout_q;
  reg                  cs_test_q;
  reg [31:0]           ctrl_q;
  reg [`LDFS_NFAULT-1:0] seen_q;
  wire                 bo_hit;
  wire                 gnd_hit;
  wire                 blanking;
  wire                 latch_fault;
  wire                 auto_fault;
  wire [`LDFS_NFAULT-1:0] faults;
  wire                 auto_live;
  wire                 wr_faults;
  wire                 cs_test_now;
  wire [31:0]          status_word;
  reg  [31:0]          rd_word;
  genvar               gi;

  ldfs_persist #(.W(32), .LIMIT(BO_BLANK_CYC)) u_bo (
    .pclk    (pclk),
    .presetn (presetn),
    .clk_en  (clk_en),
    .cond    (line_below_enter),
    .hit     (bo_hit)
  );

  ldfs_persist #(.W(32), .LIMIT(GND_CYC)) u_gnd (
    .pclk    (pclk),
    .presetn (presetn),
    .clk_en  (clk_en),
    .cond    (gnd_diode_fault),
    .hit     (gnd_hit)
  );

  assign blanking = (blank_q != 32'h0000_0000);
  // brown-out, die heat and ground fault gate the drive while present, a sense short until supply reset, with no wait state
  // die overheat inhibits
  assign faults = {brownout_q, gnd_hit, cs_short_q, die_overheat, vcc_overvoltage,
                   aux_q_flag, wod_q, thermal_overvoltage, otp_q};

  // strap is frozen at reset, so a strap change in use cannot unlatch a fault
  // variant decides which faults latch
  assign latch_fault = latch_var_q & (otp_q | thermal_overvoltage | wod_q | aux_q_flag);
  assign auto_fault = vcc_overvoltage |
                      (~latch_var_q & (otp_q | thermal_overvoltage | wod_q | aux_q_flag));

  // causes that can still be live after the delay; the short flags are
  // cleared on leaving the wait, so they must not hold it
  assign auto_live = vcc_overvoltage | otp_q | thermal_overvoltage;

  // test trigger: each start-up attempt and each pulse cut by max on-time
  assign cs_test_now = (state_q == ST_START && vcc_on) || maxon_pulse_end;

  // pulses only in run with no fault present
  assign drive_enable = (state_q == ST_RUN) & ~(|faults) & ~cs_test_q;
  assign pready  = 1'b1;
  assign pslverr = 1'b0;

  // no reset here on purpose: the capture itself happens while reset is low
  // strap caught while reset holds; release edge freezes it
  always @(posedge pclk) begin
    if (!presetn)
      latch_var_q <= latch_variant_sel;
  end

  // all timers clear under supply reset
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q           <= ST_START;
      seen_on_q         <= 1'b0;
      blank_q           <= 32'h0000_0000;
      aux_q             <= 32'h0000_0000;
      auto_q            <= 32'h0000_0000;
      short_q           <= 3'h0;
      otp_q             <= 1'b0;
      wod_q             <= 1'b0;
      aux_q_flag        <= 1'b0;
      cs_short_q        <= 1'b0;
      brownout_q        <= 1'b0;
      cs_test_q         <= 1'b0;
      startup_low_power <= 1'b1;
    end else if (clk_en) begin
      cs_test_q <= 1'b0;
      // blanking starts when supply first reaches turn-on
      if (vcc_on && !seen_on_q) begin
        seen_on_q <= 1'b1;
        blank_q   <= OTP_BLANK_CYC;
      end else if (blanking) begin
        blank_q <= blank_q - 32'h0000_0001;
      end
      if (!blanking && seen_on_q && thermal_below_otp)
        otp_q <= 1'b1;
      else if (thermal_above_recover && !latch_var_q)
        otp_q <= 1'b0;
      // latching variant keeps it until reset
      if (state_q == ST_RUN) begin
        if (valley_short_pulse)
          aux_q <= 32'h0000_0000;
        else if (aux_q >= AUX_TIMEOUT_CYC - 1)
          aux_q_flag <= 1'b1;
        else
          aux_q <= aux_q + 32'h0000_0001;
      end else begin
        aux_q <= 32'h0000_0000;
      end
      if (period_end) begin
        if (!cs_over_150)
          short_q <= 3'h0;
        else if (short_q == `LDFS_SHORT_PERIODS - 1)
          wod_q <= 1'b1;
        else
          short_q <= short_q + 3'h1;
      end
      // impedance tested at start-up and after max on-time end
      if (cs_test_now) begin
        cs_test_q <= 1'b1;
        if (cs_impedance_low)
          cs_short_q <= 1'b1;
      end
      if (bo_hit)
        brownout_q <= 1'b1;
      else if (brownout_q && line_above_exit) begin
        brownout_q        <= 1'b0;
        // drop to start-up consumption to recharge supply
        startup_low_power <= 1'b1;
        state_q           <= ST_START;
      end
      case (state_q)
        ST_START: begin
          if (vcc_on && !brownout_q) begin
            startup_low_power <= 1'b0;
            state_q           <= ST_RUN;
          end
        end
        ST_RUN: begin
          // latching faults hold until supply reset
          if (latch_fault)
            state_q <= ST_LATCH;
          else if (auto_fault) begin
            auto_q  <= AUTO_DELAY_CYC;
            state_q <= ST_AUTO;
          end
        end
        ST_AUTO: begin
          if (latch_fault)
            state_q <= ST_LATCH;
          else if (auto_q != 32'h0000_0000)
            auto_q <= auto_q - 32'h0000_0001;
          else if (!auto_live) begin
            wod_q      <= 1'b0;
            aux_q_flag <= 1'b0;
            short_q    <= 3'h0;
            state_q    <= ST_START;
          end
        end
        ST_LATCH: state_q <= ST_LATCH;
        default:  state_q <= ST_START;
      endcase
    end
  end

  // foldback: linear from full to half between start and stop levels
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      current_target <= `LDFS_FOLD_FULL;
    else if (clk_en) begin
      if (!ctrl_q[0] || !thermal_below_start)
        current_target <= `LDFS_FOLD_FULL;
      else if (thermal_below_stop)
        current_target <= `LDFS_FOLD_HALF;
      else
        current_target <= `LDFS_FOLD_FULL - {1'b0, foldback_position[7:1]};
    end
  end

  // register writes take effect at the end of the access phase
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      ctrl_q <= `LDFS_CTRL_RESET;
    else if (clk_en && psel && penable && pwrite && paddr == `LDFS_ADDR_CTRL)
      ctrl_q <= pwdata;
  end

  assign wr_faults = psel & penable & pwrite & (paddr == `LDFS_ADDR_FAULTS);

  // sticky fault history, one flop per fault; a fault present in the clear cycle wins
  generate
    for (gi = 0; gi < `LDFS_NFAULT; gi = gi + 1) begin : g_seen
      always @(posedge pclk or negedge presetn) begin
        if (!presetn)
          seen_q[gi] <= 1'b0;
        else if (clk_en) begin
          if (faults[gi])
            seen_q[gi] <= 1'b1;
          else if (wr_faults && pwdata[gi])
            seen_q[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  assign status_word = {26'h0, startup_low_power, blanking, latch_var_q,
                        state_q == ST_AUTO, state_q == ST_LATCH, drive_enable};

  // read decode; unmapped offsets read zero and never raise an error
  always @* begin
    case (paddr)
      `LDFS_ADDR_STATUS:   rd_word = status_word;
      `LDFS_ADDR_FAULTS:   rd_word = {{(32-2*`LDFS_NFAULT){1'b0}}, faults, seen_q};
      `LDFS_ADDR_CTRL:     rd_word = ctrl_q;
      `LDFS_ADDR_FOLDBACK: rd_word = {24'h0, current_target};
      default:             rd_word = 32'h0000_0000;
    endcase
  end

  // captured in the setup cycle so the word stands through the access phase;
  // live fault bits therefore show the level of the setup cycle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      prdata <= 32'h0000_0000;
    else if (clk_en && psel && !penable)
      prdata <= rd_word;
  end
endmodule // ldfs_supervisor

// File: tb/ldfs_checker.sv
// ldfs_checker.sv: port-level timing checks on the fault supervisor
// assumes clk_en high in use; bound into every ldfs_supervisor
`timescale 1ns/1ps
module ldfs_checker #(
  parameter GND_CYC         = 10,
  parameter BO_BLANK_CYC    = 50,
  parameter AUX_TIMEOUT_CYC = 80
) (
  input wire        pclk,
  input wire        presetn,
  input wire        clk_en,
  input wire        die_overheat,
  input wire        vcc_overvoltage,
  input wire        gnd_diode_fault,
  input wire        line_below_enter,
  input wire        valley_short_pulse,
  input wire        psel,
  input wire        penable,
  input wire [31:0] prdata,
  input wire        pready,
  input wire        pslverr,
  input wire        drive_enable,
  input wire [7:0]  current_target
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  reg [31:0] gnd_q, bo_q, aux_q;
  // counters freeze with clk_en, like the timers they shadow
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gnd_q <= 32'h0;
      bo_q  <= 32'h0;
      aux_q <= 32'h0;
    end else if (clk_en) begin
      gnd_q <= gnd_diode_fault ? gnd_q + 32'h1 : 32'h0;
      bo_q  <= line_below_enter ? bo_q + 32'h1 : 32'h0;
      aux_q <= (valley_short_pulse || !drive_enable) ? 32'h0 : aux_q + 32'h1;
    end
  end
  a_gnd_persist_stop:
    assert property (gnd_q > GND_CYC + 1 |-> !drive_enable) else $error("ground fault kept drive on");
  a_brownout_stop:
    assert property (bo_q > BO_BLANK_CYC + 2 |-> !drive_enable) else $error("brown-out kept drive on");
  a_aux_timeout_stop:
    assert property (aux_q > AUX_TIMEOUT_CYC + 2 |-> !drive_enable) else $error("aux timeout kept drive on");
  a_die_heat_stop:
    assert property (die_overheat [*2] |-> !drive_enable) else $error("die overheat kept drive on");
  a_vcc_ovp_stop:
    assert property (vcc_overvoltage [*2] |-> !drive_enable) else $error("supply overvoltage kept drive on");
  a_target_floor:
    assert property (current_target >= 8'h80) else $error("current target below half");
  a_apb_always_ok:
    assert property (pready && !pslverr) else $error("bus answer not ready or error");
  a_read_data_hold:
    assert property (!$past(psel && !penable) |-> $stable(prdata)) else $error("read data moved outside setup");
  cover property (gnd_q > GND_CYC + 1);
  cover property (bo_q > BO_BLANK_CYC + 2);
  cover property ($fell(drive_enable) ##1 drive_enable [*3]);
endmodule // ldfs_checker

bind ldfs_supervisor ldfs_checker #(.GND_CYC(GND_CYC), .BO_BLANK_CYC(BO_BLANK_CYC), .AUX_TIMEOUT_CYC(AUX_TIMEOUT_CYC))
  i_chk (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .die_overheat(die_overheat),
  .vcc_overvoltage(vcc_overvoltage), .gnd_diode_fault(gnd_diode_fault), .line_below_enter(line_below_enter),
  .valley_short_pulse(valley_short_pulse), .psel(psel), .penable(penable), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .drive_enable(drive_enable), .current_target(current_target));

// File: tb/ldfs_sense_model.sv
// ldfs_sense_model.sv: valley and switching-period pulses of the analog side
// assumes the bench commands the short conditions
`timescale 1ns/1ps
module ldfs_sense_model (
  input  wire pclk,
  input  wire presetn,
  input  wire drive_enable,
  input  wire aux_short,
  input  wire winding_short,
  output reg  valley_short_pulse,
  output reg  period_end,
  output wire cs_over_150
);
  reg [2:0] div_q;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_q              <= 3'h0;
      valley_short_pulse <= 1'b0;
      period_end         <= 1'b0;
    end else begin
      div_q              <= div_q + 3'h1;
      valley_short_pulse <= (div_q == 3'h0) && !aux_short;
      // periods only exist while the gate switches
      period_end         <= (div_q == 3'h4) && drive_enable;
    end
  end
  assign cs_over_150 = winding_short;
endmodule // ldfs_sense_model

// File: tb/tb_led_driver_fault_supervisor.sv
// tb_led_driver_fault_supervisor.sv: fault sequences and register reads on the supervisor
// assumes shortened timer parameters set below
`timescale 1ns/1ps
module tb_led_driver_fault_supervisor;
  localparam AUTO = 100;
  reg pclk = 1'b0, presetn = 1'b0, latch_variant_sel = 1'b0, vcc_on = 1'b1, clk_en = 1'b1, tb_start = 1'b0;
  reg tb_stop = 1'b0, tb_otp = 1'b0, tb_recover = 1'b1, tb_programmable_overvoltage_fault = 1'b0, line_below_enter = 1'b0, line_above_exit = 1'b1;
  reg die_overheat = 1'b0, vcc_overvoltage = 1'b0, cs_low = 1'b0, maxon = 1'b0, gnd_fault = 1'b0, aux_cmd = 1'b0;
  reg wod_cmd = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  reg [7:0] fold_pos = 8'h00;
  reg [11:0] paddr = 12'h000;
  reg [31:0] pwdata = 32'h0, rd;
  wire [31:0] prdata;
  wire [7:0] current_target;
  wire pready, pslverr, drive_enable, startup_low_power, valley, period_end, cs_over_150;
  integer fail_count = 0, samples_checked = 0, cyc = 0, c, v, k;
  always #20 pclk = ~pclk;
  ldfs_sense_model i_sense (.pclk(pclk), .presetn(presetn), .drive_enable(drive_enable), .aux_short(aux_cmd),
    .winding_short(wod_cmd), .valley_short_pulse(valley), .period_end(period_end), .cs_over_150(cs_over_150));
  ldfs_supervisor #(.BO_BLANK_CYC(50), .AUX_TIMEOUT_CYC(80), .AUTO_DELAY_CYC(AUTO), .OTP_BLANK_CYC(20), .GND_CYC(10))
    i_dut (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .latch_variant_sel(latch_variant_sel), .vcc_on(vcc_on),
    .thermal_below_start(tb_start), .thermal_below_stop(tb_stop), .thermal_below_otp(tb_otp),
    .thermal_above_recover(tb_recover), .thermal_overvoltage(tb_programmable_overvoltage_fault), .line_below_enter(line_below_enter),
    .line_above_exit(line_above_exit), .die_overheat(die_overheat), .vcc_overvoltage(vcc_overvoltage),
    .cs_impedance_low(cs_low), .maxon_pulse_end(maxon), .gnd_diode_fault(gnd_fault), .valley_short_pulse(valley),
    .period_end(period_end), .cs_over_150(cs_over_150), .foldback_position(fold_pos), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .drive_enable(drive_enable), .startup_low_power(startup_low_power), .current_target(current_target));
  task end_of_test;
    if (fail_count == 0 && samples_checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task chk(input string n, input [31:0] e, input [31:0] s);
    samples_checked = samples_checked + 1;
    if (e !== s) begin
      fail_count = fail_count + 1;
      $display("unexpected %s: expected %h seen %h", n, e, s);
    end
  endtask
  task apb(input w, input [11:0] a, input [31:0] d);
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    // only pready high or the bench timeout ends this wait
    while (pready !== 1'b1)
      @(posedge pclk);
    rd = prdata;
    {psel, penable} <= 2'b00;
  endtask
  task rst(input s);
    latch_variant_sel <= s;
    presetn <= 1'b0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    // the strap flips after release; the captured variant must not follow it
    latch_variant_sel <= ~s;
  endtask
  task wait_de(input e, input integer n);
    c = 0;
    while (drive_enable !== e && c < n) begin
      @(posedge pclk);
      c = c + 1;
    end
  endtask
  task set_fault(input integer f, input on);
    case (f)
      0: {tb_otp, tb_recover} <= {on, !on};
      1: tb_programmable_overvoltage_fault <= on;
      2: vcc_overvoltage <= on;
      3: wod_cmd <= on;
      4: aux_cmd <= on;
      default: die_overheat <= on;
    endcase
  endtask
  always @(posedge pclk) begin
    cyc = cyc + 1;
    if (cyc == 40000) begin
      fail_count = fail_count + 1;
      end_of_test;
    end
  end
  initial begin
    for (v = 0; v < 2; v = v + 1) begin
      for (k = 0; k < 6; k = k + 1) begin
        rst(v[0]);
        wait_de(1'b1, 300);
        chk("startup drive", 1, drive_enable);
        apb(1'b0, 12'h000, 32'h0);
        chk("variant strap", v, rd[3]);
        set_fault(k, 1'b1);
        wait_de(1'b0, 300);
        chk("otp blanked", 1, k != 0 || c > 10);
        chk("fault stop", 0, drive_enable);
        repeat (10) @(posedge pclk);
        set_fault(k, 1'b0);
        wait_de(1'b1, 400);
        if (v == 1 && k != 2 && k != 5)
          chk("latched off", 0, drive_enable);
        else
          chk("auto resume", 1, drive_enable && (k == 5 || c >= AUTO - 12));
      end
    end
    rst(1'b0);
    wait_de(1'b1, 300);
    apb(1'b0, 12'h008, 32'h0);
    chk("ctrl reset", 32'h1, rd);
    apb(1'b0, 12'h010, 32'h0);
    chk("unmapped read", 32'h0, rd);
    {tb_start, tb_stop, fold_pos} <= {2'b11, 8'hff};
    repeat (4) @(posedge pclk);
    chk("half target", 8'h80, current_target);
    apb(1'b1, 12'h008, 32'h0);
    apb(1'b0, 12'h00c, 32'h0);
    chk("foldback off", 32'hff, rd);
    apb(1'b1, 12'h008, 32'h1);
    {tb_start, tb_stop, fold_pos} <= 10'h0;
    {line_below_enter, line_above_exit} <= 2'b10;
    repeat (40) @(posedge pclk);
    chk("line dip ignored", 1, drive_enable);
    chk("full target", 8'hff, current_target);
    repeat (20) @(posedge pclk);
    chk("brown-out stop", 0, drive_enable);
    {line_below_enter, line_above_exit} <= 2'b01;
    repeat (3) @(posedge pclk);
    chk("low start draw", 1, startup_low_power);
    wait_de(1'b1, 300);
    chk("brown-out resume", 1, drive_enable);
    {clk_en, gnd_fault} <= 2'b01;
    repeat (20) @(posedge pclk);
    chk("frozen timers", 1, drive_enable);
    clk_en <= 1'b1;
    repeat (8) @(posedge pclk);
    chk("ground glitch", 1, drive_enable);
    repeat (8) @(posedge pclk);
    chk("ground stop", 0, drive_enable);
    gnd_fault <= 1'b0;
    wait_de(1'b1, 300);
    apb(1'b0, 12'h004, 32'h0);
    chk("fault history", 32'h180, rd);
    apb(1'b1, 12'h004, 32'h1ff);
    apb(1'b0, 12'h004, 32'h0);
    chk("history cleared", 32'h0, rd);
    {cs_low, maxon} <= 2'b11;
    @(posedge pclk);
    maxon <= 1'b0;
    repeat (3) @(posedge pclk);
    chk("sense short stop", 0, drive_enable);
    cs_low <= 1'b0;
    repeat (20) @(posedge pclk);
    chk("sense short held", 0, drive_enable);
    end_of_test;
  end
endmodule // tb_led_driver_fault_supervisor
